// file: logic/pbl_pkg.sv
/*
 * Constants, state encodings and timing figures for the power switch
 * sequencer and management status lamp block.
 * Assumes a free-running 100 MHz always-on clock with power-on reset.
 */
package pbl_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned SHORT_PRESS_S = 4;
    localparam int unsigned LONG_PRESS_S  = 6;
    localparam int unsigned DEBOUNCE_MS   = 20;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned SHORT_CYC     = SHORT_PRESS_S * CLK_HZ;
    localparam int unsigned LONG_CYC      = LONG_PRESS_S * CLK_HZ;
    localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned BLINK_CYC     = BLINK_HALF_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        PBL_SOFT_OFF = 2'b00,
        PBL_WORKING  = 2'b01,
        PBL_SLEEPING = 2'b10
    } pbl_state_t;

    localparam pbl_state_t STATE_RESET = PBL_SOFT_OFF;
endpackage

// file: logic/pbl_power_button.sv
/*
 * Power switch press timer, system power state machine and management
 * status lamp driver.
 * Assumes the switch input is asynchronous and active low; mgmt inputs
 * are asynchronous levels from the management controller.
 */
module pbl_power_button
    import pbl_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES    = SHORT_CYC,
    parameter int unsigned LONG_CYCLES     = LONG_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned BLINK_CYCLES    = BLINK_CYC
)(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       pwrSwitchN,
    input  wire logic       mgmtFullOn,
    input  wire logic       mgmtOutOfBandActive,
    output logic            sysPowerOn,
    output logic            sysSleep,
    output logic [1:0]      sysState,
    output logic            mgmtLamp
);
    logic [1:0]  swSync_q;
    logic [1:0]  mgmtFullSync_q;
    logic [1:0]  mgmtOobSync_q;
    logic        swDeb_q;
    logic [31:0] debCnt_q;
    logic [31:0] holdCnt_q;
    logic        swDebPrev_q;
    logic        release_w;
    pbl_state_t  state_q;
    pbl_state_t  state_d;
    logic [31:0] blinkCnt_q;
    logic        blink_q;

    // two-flop synchronisers; stage 0 read only by stage 1
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            swSync_q       <= 2'h0;
            mgmtFullSync_q <= 2'h0;
            mgmtOobSync_q  <= 2'h0;
        end
        else
        begin
            swSync_q       <= {swSync_q[0], ~pwrSwitchN};
            mgmtFullSync_q <= {mgmtFullSync_q[0], mgmtFullOn};
            mgmtOobSync_q  <= {mgmtOobSync_q[0], mgmtOutOfBandActive};
        end
    end

    // debounce: accept a new level only once it has been stable
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            swDeb_q  <= 1'b0;
            debCnt_q <= 32'h0;
        end
        else if (swSync_q[1] == swDeb_q)
            debCnt_q <= 32'h0;
        else if (debCnt_q >= DEBOUNCE_CYCLES - 1)
        begin
            swDeb_q  <= swSync_q[1];
            debCnt_q <= 32'h0;
        end
        else
            debCnt_q <= debCnt_q + 32'h1;
    end

    // hold timer saturates just above the long threshold
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            holdCnt_q   <= 32'h0;
            swDebPrev_q <= 1'b0;
        end
        else
        begin
            swDebPrev_q <= swDeb_q;
            if (!swDeb_q)
                holdCnt_q <= 32'h0;
            else if (holdCnt_q <= LONG_CYCLES)
                holdCnt_q <= holdCnt_q + 32'h1;
        end
    end

    // short presses act on release; long press acts as soon as six seconds pass
    assign release_w = swDebPrev_q && !swDeb_q;

    // press decoders; short release used by all states, long hold only by working and sleeping
    function automatic logic shortRelease(input logic rel, input logic [31:0] cnt);
        return rel && (cnt < SHORT_CYCLES);
    endfunction

    function automatic logic longReached(input logic held, input logic [31:0] cnt);
        return held && (cnt == LONG_CYCLES);
    endfunction

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PBL_SOFT_OFF:
            begin
                if (shortRelease(release_w, holdCnt_q))
                    state_d = PBL_WORKING;
            end
            PBL_WORKING:
            begin
                if (longReached(swDeb_q, holdCnt_q))
                    state_d = PBL_SOFT_OFF;
                else if (shortRelease(release_w, holdCnt_q))
                    state_d = PBL_SLEEPING;
            end
            PBL_SLEEPING:
            begin
                if (longReached(swDeb_q, holdCnt_q))
                    state_d = PBL_SOFT_OFF;
                else if (shortRelease(release_w, holdCnt_q))
                    state_d = PBL_WORKING;
            end
            default: state_d = STATE_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_q <= STATE_RESET;
        else
            state_q <= state_d;
    end

    // blink generator
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            blinkCnt_q <= 32'h0;
            blink_q    <= 1'b0;
        end
        else if (blinkCnt_q >= BLINK_CYCLES - 1)
        begin
            blinkCnt_q <= 32'h0;
            blink_q    <= ~blink_q;
        end
        else
            blinkCnt_q <= blinkCnt_q + 32'h1;
    end

    // outputs registered
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sysPowerOn <= 1'b0;
            sysSleep   <= 1'b0;
            sysState   <= 2'h0;
            mgmtLamp   <= 1'b0;
        end
        else
        begin
            sysPowerOn <= (state_q == PBL_WORKING);
            sysSleep   <= (state_q == PBL_SLEEPING);
            sysState   <= state_q;
            if (state_q == PBL_WORKING)
                mgmtLamp <= mgmtFullSync_q[1];
            else if (mgmtOobSync_q[1])
                mgmtLamp <= blink_q;
            else
                mgmtLamp <= 1'b0;
        end
    end

    sequence longHold_s;
        swDeb_q && holdCnt_q == LONG_CYCLES;
    endsequence

    sequence shortRelease_s;
        release_w && holdCnt_q < SHORT_CYCLES;
    endsequence

    chk_off_short_on: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == PBL_SOFT_OFF) and shortRelease_s
        |=> state_q == PBL_WORKING) else $error("short press from off did not power on");
    chk_work_short_sleep: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == PBL_WORKING) and shortRelease_s
        |=> state_q == PBL_SLEEPING) else $error("short press while working did not sleep");
    chk_work_long_off: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == PBL_WORKING) and longHold_s |=> state_q == PBL_SOFT_OFF)
        else $error("long press while working did not power off");
    chk_sleep_short_wake: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == PBL_SLEEPING) and shortRelease_s
        |=> state_q == PBL_WORKING) else $error("short press while asleep did not wake");
    chk_sleep_long_off: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == PBL_SLEEPING) and longHold_s |=> state_q == PBL_SOFT_OFF)
        else $error("long press while asleep did not power off");
    chk_lamp_steady_on: assert property (@(posedge clk) disable iff (!rstn)
        state_q == PBL_WORKING && mgmtFullSync_q[1] |=> mgmtLamp)
        else $error("lamp not on while working and controller full on");
    chk_lamp_blink: assert property (@(posedge clk) disable iff (!rstn)
        state_q != PBL_WORKING && mgmtOobSync_q[1] |=> mgmtLamp == $past(blink_q))
        else $error("lamp not blinking while controller active out of band");
    chk_lamp_off: assert property (@(posedge clk) disable iff (!rstn)
        state_q != PBL_WORKING && !mgmtOobSync_q[1] |=> !mgmtLamp)
        else $error("lamp lit while controller asleep and system not working");
    chk_mid_press_hold: assert property (@(posedge clk) disable iff (!rstn)
        release_w && holdCnt_q >= SHORT_CYCLES && holdCnt_q < LONG_CYCLES
        |=> $stable(state_q)) else $error("state changed on a four to six second press");
    chk_off_long_ignored: assert property (@(posedge clk) disable iff (!rstn)
        (state_q == PBL_SOFT_OFF) and longHold_s |=> state_q == PBL_SOFT_OFF)
        else $error("long press from off changed the state");
    chk_debounce_still: assert property (@(posedge clk) disable iff (!rstn)
        swSync_q[1] == swDeb_q |=> $stable(swDeb_q))
        else $error("debounced switch moved without a new input level");
    chk_release_clears: assert property (@(posedge clk) disable iff (!rstn)
        !swDeb_q |=> holdCnt_q == 32'h0)
        else $error("hold timer not cleared while the switch is released");
endmodule

// file: bench/pbl_panel_model.sv
/*
 * Front panel model: an active-low power switch with a pull-up and an
 * observer that counts changes of the status lamp.
 * Assumes the bench clock; the switch is changed on falling edges only.
 */
module pbl_panel_model
(
    input  wire logic clk,
    input  wire logic mgmtLamp,
    output logic      pwrSwitchN,
    output int        lampEdges
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        pwrSwitchN = 1'b1;
        lampEdges  = 0;
    end

    always @(mgmtLamp)
    begin
        lampEdges++;
    end

    // holds the switch pressed for a whole number of cycles, then lets the pull-up win
    task automatic press(input int hold);
        @(negedge clk) pwrSwitchN = 1'b0;
        repeat (hold) @(negedge clk);
        pwrSwitchN = 1'b1;
    endtask
endmodule

// file: bench/power_button_state_led_ctrl_tb_top.sv
/*
 * Self-checking bench for the power switch sequencer and status lamp.
 * Assumes short sim counts: 40/60 hold, 4 debounce, 5 blink half period.
 */
module power_button_state_led_ctrl_tb_top;
    import pbl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       mgmtFullOn = 1'b0;
    logic       mgmtOutOfBandActive = 1'b0;
    logic       pwrSwitchN;
    logic       sysPowerOn;
    logic       sysSleep;
    logic       mgmtLamp;
    logic [1:0] sysState;
    int         lampEdges;
    int         badCount = 0;
    int         nTests = 0;
    int         e;

    always #5 clk = ~clk;

    pbl_power_button #(.SHORT_CYCLES(40), .LONG_CYCLES(60), .DEBOUNCE_CYCLES(4),
                       .BLINK_CYCLES(5)) dut (.clk(clk), .rstn(rstn),
        .pwrSwitchN(pwrSwitchN), .mgmtFullOn(mgmtFullOn),
        .mgmtOutOfBandActive(mgmtOutOfBandActive), .sysPowerOn(sysPowerOn),
        .sysSleep(sysSleep), .sysState(sysState), .mgmtLamp(mgmtLamp));

    pbl_panel_model sw (.clk(clk), .mgmtLamp(mgmtLamp), .pwrSwitchN(pwrSwitchN),
                        .lampEdges(lampEdges));

    task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string msg);
        nTests++;
        if (got !== exp)
        begin
            badCount++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    task automatic conclude;
        if (badCount == 0 && nTests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one press, settle past sync and debounce, then judge state and flags
    task automatic step(input int hold, input logic [1:0] exp);
        sw.press(hold);
        repeat (20) @(negedge clk);
        chk(sysState, exp, "system state");
        chk({sysSleep, sysPowerOn}, {exp == 2'h2, exp == 2'h1}, "power flags");
    endtask

    // lamp level and whether it stayed still over 20 cycles
    task automatic lamp_still(input logic lvl);
        repeat (10) @(negedge clk);
        e = lampEdges;
        repeat (20) @(negedge clk);
        chk({mgmtLamp, lampEdges == e}, {lvl, 1'b1}, "steady lamp");
    endtask

    task automatic t_power_on;    step(20, 2'h1);  endtask
    task automatic t_sleep;       step(20, 2'h2);  endtask
    task automatic t_wake;        step(20, 2'h1);  endtask
    task automatic t_forced_off;  step(80, 2'h0);  endtask
    task automatic t_sleep_off;   step(80, 2'h0);  endtask
    task automatic t_off_long;    step(80, 2'h0);  endtask

    // mid-run reset: all outputs low and the system back in soft-off
    task automatic t_reset;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        chk(sysState, 2'h0, "state in reset");
        chk({sysSleep, sysPowerOn}, 2'h0, "flags in reset");
        chk({1'b0, mgmtLamp}, 2'h0, "lamp in reset");
        rstn = 1'b1;
    endtask

    task automatic t_ignored;
        step(50, 2'h2);
        step(2, 2'h2);
    endtask

    task automatic t_blink;
        mgmtOutOfBandActive = 1'b1;
        repeat (10) @(negedge clk);
        e = lampEdges;
        repeat (30) @(negedge clk);
        chk({1'b0, lampEdges - e inside {[5:7]}}, 2'h1, "lamp blink rate");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        badCount++;
        $display("CHECK FAILED t=%0t run timed out", $time);
        conclude();
    end

    initial
    begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        t_power_on();
        mgmtFullOn = 1'b1;
        lamp_still(1'b1);
        t_sleep();
        t_blink();
        t_ignored();
        t_wake();
        t_sleep();
        t_sleep_off();
        mgmtOutOfBandActive = 1'b0;
        lamp_still(1'b0);
        t_off_long();
        t_power_on();
        t_reset();
        t_power_on();
        t_forced_off();
        conclude();
    end
endmodule
